// ===== include/ddc_pkg.sv
// shared constants for the memory command decoder
package ddc_pkg;
    localparam int ADDR_W       = 19;
    localparam int MODE_W       = 18;
    localparam int BANKS        = 8;
    localparam int BANK_W       = 3;
    localparam int LANES        = 4;
    localparam int LAT_W        = 4;
    // mode register field positions
    localparam int MR_CFG_LO    = 0;
    localparam int MR_CFG_HI    = 2;
    localparam int MR_BL_LO     = 3;
    localparam int MR_BL_HI     = 4;
    localparam int MR_AMUX      = 5;
    localparam int MR_DLL       = 7;
    localparam logic [MODE_W-1:0] MODE_RESET = 18'h00000;
    // burst length encodings of bits 4:3
    localparam logic [1:0] BL2_CODE = 2'h0;
    localparam logic [1:0] BL4_CODE = 2'h1;
    localparam logic [1:0] BL8_CODE = 2'h2;
    typedef enum logic [2:0] {
        CMD_NOOP,
        CMD_MODE,
        CMD_READ,
        CMD_WRITE,
        CMD_REFRESH,
        CMD_BAD
    } ddc_cmd_e;
endpackage

// ===== src/ddc_bank_timer.sv
// busy timer for one bank, held for the row cycle time after a command
`timescale 1ns/10ps
`default_nettype none
module ddc_bank_timer
    import ddc_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             start,
    input  wire logic [LAT_W-1:0] cycles,
    output logic                  busy
);
    logic [LAT_W-1:0] count_reg;
    logic [LAT_W-1:0] count_next;

    assign count_next = start ? cycles - 4'h1 :
                        (count_reg != 4'h0) ? count_reg - 4'h1 : 4'h0;
    assign busy = (count_reg != 4'h0);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 4'h0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // ddc_bank_timer
`default_nettype wire

// ===== src/ddc_decoder.sv
// command decoder, mode register and bank busy tracking
// Contract
// R1 - capture inputs once on rising clock
// R2 - controller sends only five legal encodings
// R3 - chip select high means deselected noop
// R4 - deselected cycles accept no command
// R5 - all strobes low loads mode register
// R6 - mode load uses only low eighteen bits
// R7 - mode load only when banks idle
// R8 - wait mode cycle time after load
// R9 - read strobes start burst read
// R10 - write strobes start burst write
// R11 - write mask high leaves lanes unwritten
// R12 - refresh uses internal counter, ignores address
// R13 - each bank refresh needs own command
// R14 - burst length change invalidates contents
// R15 - bits 3,4 select burst 2/4/8
// R16 - write latency equals read latency plus one
// R17 - bit 5 enables two-clock address mux
// R18 - wait 1024 cycles after dll enable
// R19 - bank busy until row cycle time
// R20 - flag illegal strobes and busy mode load
`timescale 1ns/10ps
`default_nettype none
module ddc_decoder
    import ddc_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic                  chip_sel_n,
    input  wire logic                  write_en_n,
    input  wire logic                  refresh_n,
    input  wire logic [BANK_W-1:0]     bank_sel,
    input  wire logic [ADDR_W-1:0]     addr_bus,
    input  wire logic [LANES-1:0]      write_mask,
    output logic [MODE_W-1:0]          mode_value,
    output logic                       read_start,
    output logic                       write_start,
    output logic                       refresh_start,
    output logic [BANK_W-1:0]          op_bank,
    output logic [ADDR_W-1:0]          op_addr,
    output logic [LANES-1:0]           lane_write_en,
    output logic [3:0]                 burst_beats,
    output logic [LAT_W-1:0]           read_latency,
    output logic [LAT_W-1:0]           write_latency,
    output logic                       addr_mux_enable,
    output logic                       dll_enable_bit,
    output logic [BANKS-1:0]           bank_busy,
    output logic                       protocol_error
);
    logic                  cs_s1_reg, cs_s2_reg, we_s1_reg, we_s2_reg, rf_s1_reg, rf_s2_reg;
    logic [BANK_W-1:0]     ba_s1_reg, ba_s2_reg;
    logic [ADDR_W-1:0]     ad_s1_reg, ad_s2_reg;
    logic [LANES-1:0]      dm_s1_reg, dm_s2_reg;
    logic [MODE_W-1:0]     mode_reg;
    logic                  second_half_reg;
    logic                  rd_reg, wr_reg, rf_reg, err_reg;
    logic [BANK_W-1:0]     bank_reg;
    logic [ADDR_W-1:0]     addr_reg;
    logic [LANES-1:0]      lane_reg;
    ddc_cmd_e              cmd;
    logic [LAT_W-1:0]      trc_cycles;
    logic [2:0]            cfg;
    logic [1:0]            bl_code;
    logic                  is_mode;
    logic                  is_read;
    logic                  is_write;
    logic                  is_refresh;
    logic                  is_access;
    logic                  mux_hold;
    logic                  err_next;
    logic [BANKS-1:0]      bank_start;

    // pins are synchronised before decode; one command per rising edge
    always_ff @(posedge clock or negedge nrst) begin // see R1
        if (!nrst) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            we_s1_reg <= 1'b1;
            we_s2_reg <= 1'b1;
            rf_s1_reg <= 1'b1;
            rf_s2_reg <= 1'b1;
        end else begin
            cs_s1_reg <= chip_sel_n;
            cs_s2_reg <= cs_s1_reg;
            we_s1_reg <= write_en_n;
            we_s2_reg <= we_s1_reg;
            rf_s1_reg <= refresh_n;
            rf_s2_reg <= rf_s1_reg;
        end
    end

    // bank, address and mask take the same two stages as the strobes
    always_ff @(posedge clock or negedge nrst) begin // see R1
        if (!nrst) begin
            ba_s1_reg <= 3'h0;
            ba_s2_reg <= 3'h0;
            ad_s1_reg <= 19'h00000;
            ad_s2_reg <= 19'h00000;
            dm_s1_reg <= 4'hF;
            dm_s2_reg <= 4'hF;
        end else begin
            ba_s1_reg <= bank_sel;
            ba_s2_reg <= ba_s1_reg;
            ad_s1_reg <= addr_bus;
            ad_s2_reg <= ad_s1_reg;
            dm_s1_reg <= write_mask;
            dm_s2_reg <= dm_s1_reg;
        end
    end

    // decode; second half of a multiplexed address is not a command
    always_comb begin
        if (cs_s2_reg || second_half_reg) begin
            cmd = CMD_NOOP; // see R3 see R4
        end else begin
            case ({we_s2_reg, rf_s2_reg})
                2'b00:   cmd = CMD_MODE;    // see R5
                2'b11:   cmd = CMD_READ;    // see R9
                2'b01:   cmd = CMD_WRITE;   // see R10
                2'b10:   cmd = CMD_REFRESH; // see R12
                default: cmd = CMD_BAD;
            endcase
        end
    end

    assign cfg     = mode_reg[MR_CFG_HI:MR_CFG_LO];
    assign bl_code = mode_reg[MR_BL_HI:MR_BL_LO];
    // latency configs 0..4 map to 4,6,8,3,5 cycles; others fall to config 0
    assign read_latency = (cfg == 3'h1) ? 4'h6 :
                          (cfg == 3'h2) ? 4'h8 :
                          (cfg == 3'h3) ? 4'h3 :
                          (cfg == 3'h4) ? 4'h5 : 4'h4;
    assign write_latency   = read_latency + 4'h1; // see R16
    assign trc_cycles      = read_latency;        // see R19
    assign burst_beats     = (bl_code == BL4_CODE) ? 4'h4 :
                             (bl_code == BL8_CODE) ? 4'h8 : 4'h2; // see R15
    assign addr_mux_enable = mode_reg[MR_AMUX]; // see R17
    assign dll_enable_bit  = mode_reg[MR_DLL];
    assign mode_value      = mode_reg;

    // one-hot views of the decoded command
    assign is_mode    = (cmd == CMD_MODE);
    assign is_read    = (cmd == CMD_READ);
    assign is_write   = (cmd == CMD_WRITE);
    assign is_refresh = (cmd == CMD_REFRESH);
    assign is_access  = is_read || is_write || is_refresh;
    // these commands carry a second address half when multiplexing is on
    assign mux_hold   = addr_mux_enable && (is_mode || is_read || is_write); // see R17
    // a mode load while any bank still runs its row cycle is a protocol slip
    assign err_next   = (cmd == CMD_BAD) || (is_mode && bank_busy != 8'h00); // see R20

    // one busy timer per bank, started by any access to that bank
    genvar b;
    generate
        for (b = 0; b < BANKS; b++) begin : g_bank
            assign bank_start[b] = is_access && (ba_s2_reg == BANK_W'(b)); // see R19
            ddc_bank_timer u_timer (
                .clock  (clock),
                .nrst   (nrst),
                .start  (bank_start[b]),
                .cycles (trc_cycles),
                .busy   (bank_busy[b])
            );
        end
    endgenerate

    // mode register and the second-half marker for multiplexed addressing
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_reg        <= MODE_RESET;
            second_half_reg <= 1'b0;
        end else begin
            if (is_mode) begin
                mode_reg <= ad_s2_reg[MODE_W-1:0]; // see R5 see R6
            end
            second_half_reg <= mux_hold; // see R17
        end
    end

    // one-cycle start pulses and the protocol error pulse
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_reg  <= 1'b0;
            wr_reg  <= 1'b0;
            rf_reg  <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            rd_reg  <= is_read;
            wr_reg  <= is_write;
            rf_reg  <= is_refresh;
            err_reg <= err_next; // see R20
        end
    end

    // operation target, held until the next command that names one
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bank_reg <= 3'h0;
            addr_reg <= 19'h00000;
        end else begin
            if (is_access) begin
                bank_reg <= ba_s2_reg;
            end
            if (is_read || is_write) begin
                addr_reg <= ad_s2_reg; // refresh leaves address untouched, see R12
            end
        end
    end

    // lane enables follow the mask every cycle; only writes act on them
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lane_reg <= 4'h0;
        end else begin
            lane_reg <= ~dm_s2_reg; // see R11
        end
    end

    // registered state straight to the ports
    assign read_start     = rd_reg;
    assign write_start    = wr_reg;
    assign refresh_start  = rf_reg;
    assign op_bank        = bank_reg;
    assign op_addr        = addr_reg;
    assign lane_write_en  = lane_reg;
    assign protocol_error = err_reg;
endmodule // ddc_decoder
`default_nettype wire

// ===== verification/ddc_decoder_asserts.sv
// assertions on the memory command decoder ports
`timescale 1ns/10ps
`default_nettype none
module ddc_decoder_asserts
    import ddc_pkg::*;
(
    input wire logic              clock,
    input wire logic              nrst,
    input wire logic              chip_sel_n,
    input wire logic              write_en_n,
    input wire logic              refresh_n,
    input wire logic [MODE_W-1:0] mode_value,
    input wire logic              read_start,
    input wire logic              write_start,
    input wire logic              refresh_start,
    input wire logic [BANK_W-1:0] op_bank,
    input wire logic [3:0]        burst_beats,
    input wire logic [LAT_W-1:0]  read_latency,
    input wire logic [LAT_W-1:0]  write_latency,
    input wire logic              addr_mux_enable,
    input wire logic              dll_enable_bit,
    input wire logic [BANKS-1:0]  bank_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire logic       go  = !chip_sel_n && !addr_mux_enable;
    wire logic       ml  = !chip_sel_n && !write_en_n && !refresh_n;
    wire logic [1:0] blc = mode_value[MR_BL_HI:MR_BL_LO];
    property p_rd; go && write_en_n && refresh_n |-> ##[3:4] read_start; endproperty
    a_rd: assert property (p_rd) else $error("read start missing");
    property p_wr; go && !write_en_n && refresh_n |-> ##[3:4] write_start; endproperty
    a_wr: assert property (p_wr) else $error("write start missing");
    property p_rf; go && write_en_n && !refresh_n |-> ##[3:4] refresh_start; endproperty
    a_rf: assert property (p_rf) else $error("refresh start missing");
    property p_ds; chip_sel_n[*5] |-> !(read_start || write_start || refresh_start); endproperty
    a_ds: assert property (p_ds) else $error("pulse while deselected");
    property p_wl; write_latency == read_latency + 4'h1; endproperty
    a_wl: assert property (p_wl) else $error("write latency mismatch");
    property p_bl; burst_beats == (blc == BL4_CODE ? 4'h4 : blc == BL8_CODE ? 4'h8 : 4'h2);
    endproperty
    a_bl: assert property (p_bl) else $error("burst length mismatch");
    property p_mx; addr_mux_enable == mode_value[MR_AMUX] && dll_enable_bit == mode_value[MR_DLL];
    endproperty
    a_mx: assert property (p_mx) else $error("mode bit outputs mismatch");
    property p_ms; !$stable(mode_value) |-> $past(ml, 3) || $past(ml, 4); endproperty
    a_ms: assert property (p_ms) else $error("mode changed without load");
    property p_bz; read_start || write_start || refresh_start |-> ##[0:1] bank_busy[op_bank];
    endproperty
    a_bz: assert property (p_bz) else $error("bank not busy after command");
endmodule // ddc_decoder_asserts
bind ddc_decoder ddc_decoder_asserts u_chk (.*);
`default_nettype wire

// ===== verification/ddc_host_model.sv
// host controller model driving commands into the decoder
`timescale 1ns/10ps
`default_nettype none
module ddc_host_model
    import ddc_pkg::*;
(
    input  wire logic              clock,
    output logic                   chip_sel_n,
    output logic                   write_en_n,
    output logic                   refresh_n,
    output logic [BANK_W-1:0]      bank_sel,
    output logic [ADDR_W-1:0]      addr_bus,
    output logic [LANES-1:0]       write_mask
);
    initial chip_sel_n = 1'h1;
    initial {write_en_n, refresh_n, bank_sel, addr_bus, write_mask} = '1;
    // drive one legal encoding onto strobes, bank, address and mask
    task automatic put(input ddc_cmd_e c, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m);
        chip_sel_n = (c == CMD_NOOP);
        write_en_n = !(c == CMD_MODE || c == CMD_WRITE);
        refresh_n  = !(c == CMD_MODE || c == CMD_REFRESH);
        bank_sel   = b;
        addr_bus   = a;
        write_mask = m;
    endtask
    // one legal command for one cycle, then deselect with the bus scrambled
    task automatic send(input ddc_cmd_e c, input logic [BANK_W-1:0] b,
                        input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m);
        @(negedge clock);
        put(c, b, a, m);
        @(negedge clock);
        chip_sel_n = 1'h1;
        bank_sel   = ~b;
        addr_bus   = ~a;
    endtask
    // a command, then on the next cycle a pattern multiplexed mode must ignore
    task automatic send_pair(input ddc_cmd_e c, input ddc_cmd_e c2, input logic [BANK_W-1:0] b,
                             input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m);
        @(negedge clock);
        put(c, b, a, m);
        @(negedge clock);
        put(c2, b, ~a, m);
        @(negedge clock);
        chip_sel_n = 1'h1;
    endtask
endmodule // ddc_host_model
`default_nettype wire

// ===== verification/tb_ddc_decoder.sv
// testbench for the memory command decoder
`timescale 1ns/10ps
`default_nettype none
module tb_ddc_decoder;
    import ddc_pkg::*;
    logic                   clock = 1'h0;
    logic                   nrst = 1'h0;
    wire logic              chip_sel_n, write_en_n, refresh_n, read_start, write_start;
    wire logic              refresh_start, addr_mux_enable, dll_enable_bit, protocol_error;
    wire logic [BANK_W-1:0] bank_sel, op_bank;
    wire logic [ADDR_W-1:0] addr_bus, op_addr;
    wire logic [LANES-1:0]  write_mask, lane_write_en;
    wire logic [MODE_W-1:0] mode_value;
    wire logic [3:0]        burst_beats;
    wire logic [LAT_W-1:0]  read_latency, write_latency;
    wire logic [BANKS-1:0]  bank_busy;
    int                     n_fail, tests_run;
    logic [3:0]             rl [5] = '{4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
    logic [3:0]             bl [5] = '{4'h2, 4'h4, 4'h8, 4'h2, 4'h2};
    ddc_decoder dut (.*);
    ddc_host_model host (.*);
    initial forever #25 clock = ~clock;
    task automatic end_sim;
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // issue one command and wait a bounded time for its start pulse
    task automatic run(input ddc_cmd_e c, input logic [2:0] b, input logic [ADDR_W-1:0] a,
                       input logic [3:0] m);
        logic hit;
        hit = 1'h0;
        host.send(c, b, a, m);
        for (int k = 0; k < 6 && !hit; k++) begin
            @(posedge clock);
            #1 hit = read_start | write_start | refresh_start;
        end
        if (c == CMD_NOOP) check(hit, 1'h0, "deselect pulse");
        else if (!hit) begin
            n_fail++;
            end_sim;
        end
        else check({read_start, write_start, refresh_start},
                   {c == CMD_READ, c == CMD_WRITE, c == CMD_REFRESH}, "pulse kind");
    endtask
    initial begin
        logic [ADDR_W-1:0] a;
        logic [3:0]        n_wr;
        logic [3:0]        n_rf;
        repeat (3) @(posedge clock);
        @(negedge clock) nrst = 1'h1;
        for (int i = 0; i < 5; i++) begin
            a = 19'h40000 + ADDR_W'(8 * (i % 4) + i);
            host.send(CMD_MODE, 3'h7, a, 4'hF); // burst length changes; no data read back
            repeat (4) @(negedge clock);
            check(mode_value, a[MODE_W-1:0], "mode value");
            check(read_latency, rl[i], "read latency");
            check(write_latency, rl[i] + 4'h1, "write latency");
            check(burst_beats, bl[i], "burst beats");
        end
        host.send(CMD_MODE, 3'h0, 19'h00002, 4'hF);
        repeat (4) @(negedge clock);
        run(CMD_READ, 3'h2, 19'h1ABCD, 4'hF);
        check({op_bank, op_addr}, {3'h2, 19'h1ABCD}, "read target");
        check(bank_busy, 8'h04, "busy after read");
        run(CMD_WRITE, 3'h5, 19'h0F0F0, 4'h5);
        check({op_bank, op_addr, lane_write_en}, {3'h5, 19'h0F0F0, 4'hA}, "write");
        run(CMD_NOOP, 3'h1, 19'h00000, 4'h5);
        for (int b = 0; b < 8; b++) begin
            run(CMD_REFRESH, 3'(b), 19'h7FFFF, 4'h5);
            check({op_bank, op_addr}, {3'(b), 19'h0F0F0}, "refresh target");
        end
        host.send(CMD_MODE, 3'h0, 19'h00002, 4'hF);
        a = 19'h0;
        for (int k = 0; k < 8 && a == 19'h0; k++) begin
            @(posedge clock);
            #1 a = ADDR_W'(protocol_error);
        end
        check(a, 19'h1, "busy mode load flag");
        repeat (12) @(negedge clock);
        // dll enabled here and no read follows before reset
        host.send(CMD_MODE, 3'h0, 19'h000A0, 4'hF);
        repeat (4) @(negedge clock);
        check({addr_mux_enable, dll_enable_bit}, 2'h3, "mux and dll bits");
        check(bank_busy, 8'h00, "banks idle");
        host.send_pair(CMD_WRITE, CMD_REFRESH, 3'h4, 19'h00123, 4'h0);
        n_wr = 4'h0;
        n_rf = 4'h0;
        repeat (6) begin
            @(posedge clock);
            #1 n_wr = n_wr + 4'(write_start);
            n_rf = n_rf + 4'(refresh_start);
        end
        check(n_wr, 4'h1, "mux write pulses");
        check(n_rf, 4'h0, "mux second half pulses");
        @(negedge clock);
        nrst = 1'h0;
        @(negedge clock) nrst = 1'h1;
        check({mode_value, read_latency, write_latency, burst_beats},
              {18'h00000, 4'h4, 4'h5, 4'h2}, "reset values");
        end_sim;
    end
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        end_sim;
    end
endmodule // tb_ddc_decoder
`default_nettype wire
